//--- rtl/trl_pkg.sv
// Constants and types for the thermal relay measurement loop
package trl_pkg;

	// Nonvolatile word addresses
	localparam logic [7:0] NV_PULSE_CFG = 8'h02;
	localparam logic [7:0] NV_MEAS_CFG  = 8'h05;
	localparam logic [7:0] NV_HYST      = 8'h20;
	localparam logic [7:0] NV_THRESH    = 8'h21;
	localparam logic [1:0] NV_LAST_IDX  = 2'h3;

	// Pulse output configuration bits (word 002h)
	localparam int PC_ENABLE_BIT   = 1;
	localparam int PC_DRIVE_OD_BIT = 2;
	localparam int PC_RELAY_BIT    = 3;

	// Measurement configuration fields
	localparam int MC_DUAL_BIT    = 0;
	localparam int MC_DIE_SEL_BIT = 1;
	localparam int MC_FIRN_LSB    = 8;
	localparam int MC_IIRL_LSB    = 11;

	// Filter lengths as powers of two
	localparam logic [2:0] FIX_FIR_LOG2 = 3'h3;
	localparam logic [2:0] FIX_IIR_LOG2 = 3'h2;

	// Front end channels
	localparam logic [2:0] CH_DIE_OFS = 3'h0;
	localparam logic [2:0] CH_DIE_A   = 3'h1;
	localparam logic [2:0] CH_DIE_B   = 3'h2;
	localparam logic [2:0] CH_TP_OFS  = 3'h3;
	localparam logic [2:0] CH_GAIN    = 3'h4;
	localparam logic [2:0] CH_ZONE1   = 3'h5;
	localparam logic [2:0] CH_ZONE2   = 3'h6;

	// Loop steps; each result but the pulse word lands in the scratch slot of its step
	localparam logic [3:0] ST_DIE_OFS = 4'h0;
	localparam logic [3:0] ST_DIE     = 4'h1;
	localparam logic [3:0] ST_AMB     = 4'h2;
	localparam logic [3:0] ST_TP_OFS  = 4'h3;
	localparam logic [3:0] ST_GAIN    = 4'h4;
	localparam logic [3:0] ST_GCORR   = 4'h5;
	localparam logic [3:0] ST_ZONE1   = 4'h6;
	localparam logic [3:0] ST_OBJ1    = 4'h7;
	localparam logic [3:0] ST_ZONE2   = 4'h8;
	localparam logic [3:0] ST_OBJ2    = 4'h9;
	localparam logic [3:0] ST_PWM     = 4'hA;
	localparam int         RAM_DEPTH  = 11;

	// Arithmetic constants
	localparam logic [15:0] AMB_BIAS    = 16'h2DE4;
	localparam logic [15:0] GAIN_UNITY  = 16'h0100;
	localparam logic [15:0] GAIN_REF    = 16'h0100;
	localparam int          GAIN_SHIFT  = 8;
	localparam logic [9:0]  PWM_FULL    = 10'h3FF;
	localparam logic [3:0]  PWM_TOP_BIT = 4'h9;

	// Serial request timing: longer than 1.44 ms at 50 MHz
	localparam int REQ_TIME_NS = 1440000;
	localparam int CLK_NS      = 20;
	localparam int REQ_CYCLES  = (REQ_TIME_NS + CLK_NS - 1) / CLK_NS;

	// Sequencer states
	typedef enum logic [7:0] {
		S_NVREQ  = 8'h01,
		S_NVWAIT = 8'h02,
		S_SREQ   = 8'h04,
		S_SWAIT  = 8'h08,
		S_STORE  = 8'h10,
		S_CALC   = 8'h20,
		S_DIV    = 8'h40,
		S_PWMLD  = 8'h80
	} trl_state_t;

endpackage : trl_pkg

//--- rtl/trl_relay_out.sv
// Relay comparator and shared output pin driver
`timescale 1ns/100ps
`default_nettype none
module trl_relay_out
	import trl_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Comparator inputs
	input  wire logic        update,
	input  wire logic [15:0] objTemp,
	input  wire logic [15:0] threshold,
	input  wire logic [15:0] hysteresis,
	// Driver control
	input  wire logic        relayMode,
	input  wire logic        outEnable,
	input  wire logic        openDrain,
	input  wire logic        pwmWave,
	// Pin
	output logic             pinOut,
	output logic             pinOe_n,
	output logic             relayLevel
);

	////////////////////////////////////////////////////////////////////
	// Limits, widened so neither sum nor difference wraps
	logic        [16:0] hiLimit;
	logic signed [17:0] loLimit;
	logic               atHigh;
	logic               atLow;
	logic               drive;
	assign hiLimit = {1'b0, threshold} + {1'b0, hysteresis};
	assign loLimit = $signed({2'b00, threshold}) - $signed({2'b00, hysteresis});
	assign atHigh  = {1'b0, objTemp} >= hiLimit;
	assign atLow   = $signed({2'b00, objTemp}) <= loLimit;
	assign drive   = relayMode ? relayLevel : pwmWave;

	// Level only moves at a limit; high wins if limits meet
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			relayLevel <= 1'b0;
		else if (update && atHigh)
			relayLevel <= 1'b1;
		else if (update && atLow)
			relayLevel <= 1'b0;
	end

	// Open drain only pulls low; released pin is pulled up outside
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !outEnable)
		begin
			pinOut  <= 1'b0;
			pinOe_n <= 1'b1;
		end
		else if (openDrain)
		begin
			pinOut  <= 1'b0;
			pinOe_n <= drive;
		end
		else
		begin
			pinOut  <= drive;
			pinOe_n <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	a_relay_high: assert property (@(posedge mclk) disable iff (sys_rst)
		update && atHigh |=> relayLevel)
		else $error("relay not high at upper limit");
	a_relay_low: assert property (@(posedge mclk) disable iff (sys_rst)
		update && atLow && !atHigh |=> !relayLevel)
		else $error("relay not low at lower limit");
	a_relay_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(!update || (!atHigh && !atLow)) |=> $stable(relayLevel))
		else $error("relay moved inside hysteresis band");
	a_drive_od: assert property (@(posedge mclk) disable iff (sys_rst)
		outEnable && openDrain |=> !pinOut && (pinOe_n == $past(drive)))
		else $error("open drain drove pin high");
	a_drive_pp: assert property (@(posedge mclk) disable iff (sys_rst)
		outEnable && !openDrain && relayMode
		|=> !pinOe_n && (pinOut == $past(relayLevel)))
		else $error("push-pull pin does not follow relay");

	c_relay_rise: cover property (@(posedge mclk) disable iff (sys_rst)
		$rose(relayLevel));
	c_relay_fall: cover property (@(posedge mclk) disable iff (sys_rst)
		$fell(relayLevel));

endmodule : trl_relay_out
`default_nettype wire

//--- rtl/trl_measure_loop.sv
// Measurement loop sequencer with serial request and relay output
`timescale 1ns/100ps
`default_nettype none
module trl_measure_loop
	import trl_pkg::*;
#(
	parameter int REQ_COUNT = REQ_CYCLES
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Nonvolatile calibration read port
	output logic [7:0]       nvAddr,
	output logic             nvRd,
	input  wire logic        nvValid,
	input  wire logic [15:0] nvData,
	// Analog front end sample port
	output logic             sampReq,
	output logic [2:0]       sampChan,
	input  wire logic        sampValid,
	input  wire logic [15:0] sampData,
	// Serial clock pin and wake event
	input  wire logic        sclIn,
	input  wire logic        sleepExit,
	// Pulse output module
	input  wire logic        pwmWave,
	output logic [9:0]       pwmWord,
	output logic             pwmLoad,
	// Shared output pin
	output logic             pinOut,
	output logic             pinOe_n,
	// Results and status
	output logic [15:0]      ambientResult,
	output logic [15:0]      object1Temperature,
	output logic [15:0]      object2Temperature,
	output logic             initDone,
	output logic             smbusMode
);

	////////////////////////////////////////////////////////////////////
	// State
	trl_state_t         state_reg;
	logic [3:0]         step_reg;
	logic [1:0]         initIdx_reg;
	logic [15:0]        pulseCfg_reg;
	logic [15:0]        measCfg_reg;
	logic [15:0]        hyst_reg;
	logic [15:0]        thresh_reg;
	logic [22:0]        acc_reg;
	logic [7:0]         cnt_reg;
	logic [15:0]        ram_reg [0:RAM_DEPTH-1];
	logic [25:0]        num_reg;
	logic [15:0]        den_reg;
	logic [9:0]         quo_reg;
	logic [3:0]         bit_reg;
	logic               relayUpd_reg;
	logic               sclMeta_reg;
	logic               sclSync_reg;
	logic [16:0]        lowCnt_reg;

	////////////////////////////////////////////////////////////////////
	// Step decode
	logic       measStep;
	logic       progStep;
	logic       zoneStep;
	logic       dualZone;
	logic [3:0] stepAfter;
	logic       afterMeas;
	logic [2:0] firLog2;
	logic [2:0] iirLog2;
	logic [2:0] chanSel;
	assign dualZone = measCfg_reg[MC_DUAL_BIT];
	assign measStep = step_reg == ST_DIE_OFS || step_reg == ST_DIE
		|| step_reg == ST_TP_OFS || step_reg == ST_GAIN || zoneStep;
	assign zoneStep = step_reg == ST_ZONE1 || step_reg == ST_ZONE2;
	assign progStep = step_reg == ST_DIE || zoneStep;
	// Shared lengths for every programmable filter
	assign firLog2 = progStep ? measCfg_reg[MC_FIRN_LSB +: 3]
		: FIX_FIR_LOG2;
	assign iirLog2 = progStep ? measCfg_reg[MC_IIRL_LSB +: 3]
		: FIX_IIR_LOG2;
	// Single zone parts skip straight to the pulse word
	assign stepAfter = (step_reg == ST_OBJ1 && !dualZone) ? ST_PWM
		: (step_reg == ST_PWM) ? ST_DIE_OFS : step_reg + 4'h1;
	assign afterMeas = stepAfter == ST_DIE_OFS || stepAfter == ST_DIE
		|| stepAfter == ST_TP_OFS || stepAfter == ST_GAIN
		|| stepAfter == ST_ZONE1 || stepAfter == ST_ZONE2;
	assign chanSel = (step_reg == ST_DIE_OFS) ? CH_DIE_OFS
		: (step_reg == ST_DIE) ? (measCfg_reg[MC_DIE_SEL_BIT] ? CH_DIE_B
			: CH_DIE_A)
		: (step_reg == ST_TP_OFS) ? CH_TP_OFS
		: (step_reg == ST_GAIN) ? CH_GAIN
		: (step_reg == ST_ZONE1) ? CH_ZONE1 : CH_ZONE2;

	////////////////////////////////////////////////////////////////////
	// Filter datapath: average, offset, gain, recursive filter
	logic        [22:0] accShift;
	logic        [15:0] avgVal;
	logic        [15:0] offsetVal;
	logic signed [19:0] compVal;
	logic signed [39:0] gainProd;
	logic signed [19:0] filtIn;
	logic signed [19:0] prevVal;
	logic signed [19:0] deltaVal;
	logic signed [19:0] iirSum;
	logic        [15:0] iirOut;
	assign accShift  = acc_reg >> firLog2;
	assign avgVal    = accShift[15:0];
	assign offsetVal = (step_reg == ST_DIE) ? ram_reg[ST_DIE_OFS]
		: (step_reg == ST_GAIN || zoneStep) ? ram_reg[ST_TP_OFS]
		: 16'h0000;
	assign compVal  = $signed({4'h0, avgVal}) - $signed({4'h0, offsetVal});
	assign gainProd = compVal * $signed({4'h0, ram_reg[ST_GCORR]});
	assign filtIn   = zoneStep ? gainProd[GAIN_SHIFT +: 20] : compVal;
	assign prevVal  = $signed({4'h0, ram_reg[step_reg]});
	assign deltaVal = filtIn - prevVal;
	assign iirSum   = prevVal + (deltaVal >>> iirLog2);
	// Saturate rather than wrap a cold or hot extreme
	assign iirOut = iirSum[19] ? 16'h0000
		: (|iirSum[18:16]) ? 16'hFFFF : iirSum[15:0];

	// Calculation steps
	logic [15:0] calcOut;
	logic [15:0] ramWrData;
	logic        ramWe;
	logic        lastSample;
	assign calcOut = (step_reg == ST_AMB) ? ram_reg[ST_DIE] + AMB_BIAS
		: (step_reg == ST_GCORR) ? GAIN_UNITY + GAIN_REF
			- ram_reg[ST_GAIN]
		: (step_reg == ST_OBJ1) ? ram_reg[ST_ZONE1] + ram_reg[ST_AMB]
		: ram_reg[ST_ZONE2] + ram_reg[ST_AMB];
	assign ramWe = (state_reg == S_STORE && measStep)
		|| (state_reg == S_CALC && step_reg != ST_PWM);
	assign ramWrData  = (state_reg == S_STORE) ? iirOut : calcOut;
	assign lastSample = cnt_reg == (8'h01 << firLog2) - 8'h01;

	// Rescale inputs; threshold and hysteresis words double as range
	logic        objBelow;
	logic        objAbove;
	logic [15:0] rangeSpan;
	logic [25:0] scaledNum;
	logic [25:0] trialDen;
	assign objBelow  = ram_reg[ST_OBJ1] <= thresh_reg;
	assign objAbove  = ram_reg[ST_OBJ1] >= hyst_reg;
	assign rangeSpan = hyst_reg - thresh_reg;
	assign scaledNum = 26'(({10'h000, ram_reg[ST_OBJ1] - thresh_reg})
		* {16'h0000, PWM_FULL});
	assign trialDen  = 26'({10'h000, den_reg} << bit_reg);

	////////////////////////////////////////////////////////////////////
	// Sequencer: calibration load, then the endless loop
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_reg   <= S_NVREQ;
			step_reg    <= ST_DIE_OFS;
			initIdx_reg <= 2'h0;
			initDone    <= 1'b0;
		end
		else
		begin
			case (state_reg)
				S_NVREQ:
					state_reg <= S_NVWAIT;
				S_NVWAIT:
					if (nvValid && initIdx_reg == NV_LAST_IDX)
					begin
						initDone  <= 1'b1;
						state_reg <= S_SREQ;
					end
					else if (nvValid)
					begin
						initIdx_reg <= initIdx_reg + 2'h1;
						state_reg   <= S_NVREQ;
					end
				S_SREQ:
					state_reg <= S_SWAIT;
				S_SWAIT:
					if (sampValid)
						state_reg <= lastSample ? S_STORE : S_SREQ;
				S_STORE, S_CALC:
				begin
					if (state_reg == S_CALC && step_reg == ST_PWM)
						state_reg <= S_DIV;
					else
					begin
						step_reg  <= stepAfter;
						state_reg <= afterMeas ? S_SREQ : S_CALC;
					end
				end
				S_DIV:
					if (bit_reg == 4'h0)
						state_reg <= S_PWMLD;
				S_PWMLD:
				begin
					step_reg  <= ST_DIE_OFS;
					state_reg <= S_SREQ;
				end
				default:
					state_reg <= S_NVREQ;
			endcase
		end
	end

	// Calibration words captured in load order
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pulseCfg_reg <= 16'h0000;
			measCfg_reg  <= 16'h0000;
			hyst_reg     <= 16'h0000;
			thresh_reg   <= 16'h0000;
		end
		else if (state_reg == S_NVWAIT && nvValid)
		begin
			if (initIdx_reg == 2'h0)
				pulseCfg_reg <= nvData;
			else if (initIdx_reg == 2'h1)
				measCfg_reg <= nvData;
			else if (initIdx_reg == 2'h2)
				hyst_reg <= nvData;
			else
				thresh_reg <= nvData;
		end
	end

	// Request strobes; address and channel stand until the next one
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			nvRd     <= 1'b0;
			nvAddr   <= NV_PULSE_CFG;
			sampReq  <= 1'b0;
			sampChan <= CH_DIE_OFS;
		end
		else
		begin
			nvRd    <= state_reg == S_NVREQ;
			sampReq <= state_reg == S_SREQ;
			if (state_reg == S_NVREQ)
				nvAddr <= (initIdx_reg == 2'h0) ? NV_PULSE_CFG
					: (initIdx_reg == 2'h1) ? NV_MEAS_CFG
					: (initIdx_reg == 2'h2) ? NV_HYST : NV_THRESH;
			if (state_reg == S_SREQ)
				sampChan <= chanSel;
		end
	end

	// Sample accumulation for the averaging filter
	always_ff @(posedge mclk)
	begin
		if (sys_rst || state_reg == S_STORE)
		begin
			acc_reg <= 23'h000000;
			cnt_reg <= 8'h00;
		end
		else if (state_reg == S_SWAIT && sampValid)
		begin
			acc_reg <= acc_reg + {7'h00, sampData};
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// Scratch results, one slot per step
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			for (int i = 0; i < RAM_DEPTH; i++)
				ram_reg[i] <= 16'h0000;
		else if (ramWe)
			ram_reg[step_reg] <= ramWrData;
	end

	// Restoring division, one quotient bit a cycle, clamped at the ends
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			num_reg <= 26'h0000000;
			den_reg <= 16'h0000;
			quo_reg <= 10'h000;
			bit_reg <= 4'h0;
		end
		else if (state_reg == S_CALC && step_reg == ST_PWM)
		begin
			num_reg <= objBelow ? 26'h0000000 : scaledNum;
			den_reg <= rangeSpan;
			quo_reg <= (objAbove && !objBelow) ? PWM_FULL : 10'h000;
			bit_reg <= PWM_TOP_BIT;
		end
		else if (state_reg == S_DIV)
		begin
			if (num_reg >= trialDen && den_reg != 16'h0000)
			begin
				num_reg          <= num_reg - trialDen;
				quo_reg[bit_reg] <= 1'b1;
			end
			bit_reg <= bit_reg - 4'h1;
		end
	end

	// Pulse word load and relay update strobes
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pwmWord      <= 10'h000;
			pwmLoad      <= 1'b0;
			relayUpd_reg <= 1'b0;
		end
		else
		begin
			pwmLoad      <= state_reg == S_PWMLD;
			relayUpd_reg <= state_reg == S_CALC && step_reg == ST_OBJ1;
			if (state_reg == S_PWMLD)
				pwmWord <= quo_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial request: clock held low past the request time
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sclMeta_reg <= 1'b1;
			sclSync_reg <= 1'b1;
		end
		else
		begin
			sclMeta_reg <= sclIn;
			sclSync_reg <= sclMeta_reg;
		end
	end

	logic pulseOn;
	logic reqHit;
	assign pulseOn = initDone && pulseCfg_reg[PC_ENABLE_BIT] && !smbusMode;
	assign reqHit  = pulseOn && !sclSync_reg
		&& lowCnt_reg == 17'(REQ_COUNT - 1);

	// Request wins over a coincident wake; only wake or reset clears
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			lowCnt_reg <= 17'h00000;
			smbusMode  <= 1'b0;
		end
		else
		begin
			if (sclSync_reg || !pulseOn)
				lowCnt_reg <= 17'h00000;
			else if (!reqHit)
				lowCnt_reg <= lowCnt_reg + 17'h00001;
			if (reqHit)
				smbusMode <= 1'b1;
			else if (sleepExit)
				smbusMode <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Relay comparator and shared driver
	trl_relay_out i_trl_relay_out (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.update     (relayUpd_reg),
		.objTemp    (ram_reg[ST_OBJ1]),
		.threshold  (thresh_reg),
		.hysteresis (hyst_reg),
		.relayMode  (pulseCfg_reg[PC_RELAY_BIT]),
		.outEnable  (pulseOn),
		.openDrain  (pulseCfg_reg[PC_DRIVE_OD_BIT]),
		.pwmWave    (pwmWave),
		.pinOut     (pinOut),
		.pinOe_n    (pinOe_n),
		.relayLevel ()
	);

	assign ambientResult      = ram_reg[ST_AMB];
	assign object1Temperature = ram_reg[ST_OBJ1];
	assign object2Temperature = ram_reg[ST_OBJ2];

	////////////////////////////////////////////////////////////////////
	// Checks
	a_init_first: assert property (@(posedge mclk) disable iff (sys_rst)
		!initDone |-> !sampReq)
		else $error("sample requested before calibration load");
	a_loop_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
		state_reg == S_PWMLD |=> state_reg == S_SREQ
		&& step_reg == ST_DIE_OFS)
		else $error("loop did not restart");
	a_pwm_word: assert property (@(posedge mclk) disable iff (sys_rst)
		state_reg == S_PWMLD |=> pwmLoad && pwmWord == $past(quo_reg))
		else $error("pulse word not loaded");
	a_zone_skip: assert property (@(posedge mclk) disable iff (sys_rst)
		sampReq && !dualZone |-> sampChan != CH_ZONE2)
		else $error("second zone sampled in single mode");
	a_serial_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		smbusMode && !sleepExit |=> smbusMode)
		else $error("serial mode left without wake");
	a_step_order: assert property (@(posedge mclk) disable iff (sys_rst)
		state_reg == S_STORE && step_reg == ST_DIE_OFS
		|=> step_reg == ST_DIE ##0 state_reg == S_SREQ)
		else $error("die step did not follow offset");

	c_pwm_load: cover property (@(posedge mclk) disable iff (sys_rst)
		pwmLoad);
	c_serial_req: cover property (@(posedge mclk) disable iff (sys_rst)
		$rose(smbusMode));
	c_dual_zone: cover property (@(posedge mclk) disable iff (sys_rst)
		sampReq && sampChan == CH_ZONE2);

endmodule : trl_measure_loop
`default_nettype wire

//--- test/trl_front_model.sv
// Calibration memory and sample source facing the loop
`timescale 1ns/100ps
`default_nettype none
module trl_front_model
	import trl_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Requests from the loop
	input  wire logic        nvRd,
	input  wire logic [7:0]  nvAddr,
	input  wire logic        sampReq,
	input  wire logic [2:0]  sampChan,
	// Stored words and pacing
	input  wire logic        slow,
	input  wire logic [15:0] cfgPulse,
	input  wire logic [15:0] cfgMeas,
	input  wire logic [15:0] hystWord,
	input  wire logic [15:0] thrWord,
	// Answers
	output logic             nvValid,
	output logic [15:0]      nvData,
	output logic             sampValid,
	output logic [15:0]      sampData
);
	logic [2:0]  nvCnt;
	logic [2:0]  smCnt;
	logic [15:0] nvWord;
	// Word lookup by address
	assign nvWord = (nvAddr == NV_PULSE_CFG) ? cfgPulse :
		(nvAddr == NV_MEAS_CFG) ? cfgMeas :
		(nvAddr == NV_HYST) ? hystWord : thrWord;
	// Idle data toggles so a stale value is never mistaken for an answer
	always_ff @(posedge mclk)
	begin
		nvValid   <= nvCnt == 3'h1;
		sampValid <= smCnt == 3'h1;
		nvData    <= (nvCnt == 3'h1) ? nvWord : ~nvData;
		sampData  <= (smCnt == 3'h1) ? {5'h00, sampChan, 8'h40} : ~sampData;
		nvCnt     <= sys_rst ? 3'h0 : nvRd ? (slow ? 3'h4 : 3'h1) :
			nvCnt - {2'h0, |nvCnt};
		smCnt     <= sys_rst ? 3'h0 : sampReq ? (slow ? 3'h3 : 3'h1) :
			smCnt - {2'h0, |smCnt};
	end
endmodule : trl_front_model
`default_nettype wire

//--- test/trl_measure_loop_tb.sv
// Self-checking bench for the measurement loop and relay pin
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module trl_measure_loop_tb;
	import trl_pkg::*;
	localparam int REQ = 20;
	localparam logic [17:0] ORD_DUAL = {3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
	localparam logic [17:0] ORD_ONE  = {3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
	logic        mclk, sys_rst, nvRd, nvValid, sampReq, sampValid, slow;
	logic        sclIn, sleepExit, pwmLoad, pinOut, pinOe_n, initDone;
	logic        smbusMode, pwmWave;
	logic [7:0]  nvAddr;
	logic [2:0]  sampChan, lastCh;
	logic [15:0] nvData, sampData, cfgPulse, cfgMeas, hystWord, thrWord;
	logic [15:0] amb, obj1, obj2;
	logic [9:0]  pwmWord, lastWord;
	logic [17:0] chanLog;
	int          errors, n_compared, cyc, loads, nLog, preInit;
	////////////////////////////////////////
	trl_measure_loop #(.REQ_COUNT(REQ)) i_trl_measure_loop (.mclk(mclk),
		.sys_rst(sys_rst), .nvAddr(nvAddr), .nvRd(nvRd), .nvValid(nvValid),
		.nvData(nvData), .sampReq(sampReq), .sampChan(sampChan),
		.sampValid(sampValid), .sampData(sampData), .sclIn(sclIn),
		.sleepExit(sleepExit), .pwmWave(pwmWave), .pwmWord(pwmWord),
		.pwmLoad(pwmLoad), .pinOut(pinOut), .pinOe_n(pinOe_n),
		.ambientResult(amb), .object1Temperature(obj1),
		.object2Temperature(obj2),
		.initDone(initDone), .smbusMode(smbusMode));
	trl_front_model i_trl_front_model (.mclk(mclk), .sys_rst(sys_rst),
		.nvRd(nvRd), .nvAddr(nvAddr), .sampReq(sampReq), .sampChan(sampChan),
		.slow(slow), .cfgPulse(cfgPulse), .cfgMeas(cfgMeas),
		.hystWord(hystWord), .thrWord(thrWord), .nvValid(nvValid),
		.nvData(nvData), .sampValid(sampValid), .sampData(sampData));
	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Watch requests and loads; cut a hang short
	always @(posedge mclk)
	begin
		cyc++;
		if (sampReq === 1'b1)
		begin
			if (initDone !== 1'b1) preInit++;
			if (sampChan !== lastCh && nLog < 6)
			begin
				chanLog = {chanLog[14:0], sampChan};
				nLog++;
			end
			lastCh = sampChan;
		end
		if (pwmLoad === 1'b1)
		begin
			loads++;
			lastWord = pwmWord;
		end
		if (cyc == 20000)
		begin
			errors++;
			end_of_test();
		end
	end
	////////////////////////////////////////
	task automatic boot(input logic [15:0] pc, mc, th, hy, input logic sl);
		@(posedge mclk);
		#2 sys_rst = 1'b1;
		{cfgPulse, cfgMeas, thrWord, hystWord, slow} = {pc, mc, th, hy, sl};
		{chanLog, nLog, loads, preInit, lastCh} = {18'h0, 32'h0, 64'h0, 3'h7};
		repeat (2) @(posedge mclk);
		#2 sys_rst = 1'b0;
	endtask : boot
	// Bounded wait for a number of pulse-word loads since reset
	task automatic wait_loads(input int n);
		int k;
		k = 0;
		while (loads < n && k < 5000)
		begin
			@(posedge mclk);
			k++;
		end
		#2;
	endtask : wait_loads
	task automatic test_high;
		boot(16'h000A, 16'h0001, 16'h0001, 16'h0001, 1'b0);
		wait_loads(2);
		`CHK("initDone", 1'b1, initDone)
		`CHK("chanLog", ORD_DUAL, chanLog)
		`CHK("pinOe_n", 1'b0, pinOe_n)
		`CHK("pinOut", 1'b1, pinOut)
		`CHK("pwmWord", 10'h3FF, lastWord)
		`CHK("obj2Dual", 1'b1, obj2 != 16'h0000)
		`CHK("ambient", 1'b1, amb != 16'h0000)
		$display("test_high done");
	endtask : test_high
	// Short low must not switch; a long one must, and wake restores relay
	task automatic test_serial;
		sclIn = 1'b0;
		repeat (REQ - 4) @(posedge mclk);
		#2 sclIn = 1'b1;
		repeat (4) @(posedge mclk);
		#2;
		`CHK("smbusShort", 1'b0, smbusMode)
		sclIn = 1'b0;
		repeat (REQ + 4) @(posedge mclk);
		#2 sclIn = 1'b1;
		wait_loads(loads + 1);
		`CHK("smbusMode", 1'b1, smbusMode)
		`CHK("pinOffOe", 1'b1, pinOe_n)
		sleepExit = 1'b1;
		@(posedge mclk);
		#2 sleepExit = 1'b0;
		wait_loads(loads + 1);
		`CHK("smbusOff", 1'b0, smbusMode)
		`CHK("pinBack", 1'b1, pinOut)
		$display("test_serial done");
	endtask : test_serial
	task automatic test_low;
		boot(16'h000E, 16'h0001, 16'hFFF0, 16'h000F, 1'b1);
		wait_loads(2);
		`CHK("pinOut", 1'b0, pinOut)
		`CHK("pinOe_n", 1'b0, pinOe_n)
		`CHK("pwmWord", 10'h000, lastWord)
		$display("test_low done");
	endtask : test_low
	// Single zone with second die sensor, slow answers, open drain high
	task automatic test_order;
		boot(16'h000E, 16'h0002, 16'h0001, 16'h0001, 1'b1);
		wait_loads(2);
		`CHK("preInit", 0, preInit)
		`CHK("chanLog", ORD_ONE, chanLog)
		`CHK("loopRuns", 1'b1, loads >= 2)
		`CHK("obj2Skip", 16'h0000, obj2)
		`CHK("odHighOut", 1'b0, pinOut)
		`CHK("odHighOe", 1'b1, pinOe_n)
		$display("test_order done");
	endtask : test_order
	// Object one inside the band: level keeps its low start value
	task automatic test_band;
		boot(16'h000A, 16'h0001, 16'h2000, 16'h1800, 1'b0);
		wait_loads(2);
		`CHK("objInBand", 1'b1, obj1 > 16'h0800 && obj1 < 16'h3800)
		`CHK("pinHold", 1'b0, pinOut)
		`CHK("pinHoldOe", 1'b0, pinOe_n)
		$display("test_band done");
	endtask : test_band
	// Plain pulse mode: the pin follows the waveform one cycle late
	task automatic test_pwm;
		boot(16'h0002, 16'h0001, 16'h0001, 16'h0001, 1'b0);
		wait_loads(1);
		pwmWave = 1'b1;
		repeat (2) @(posedge mclk);
		#2;
		`CHK("pwmPinHi", 1'b1, pinOut)
		`CHK("pwmPinOe", 1'b0, pinOe_n)
		pwmWave = 1'b0;
		repeat (2) @(posedge mclk);
		#2;
		`CHK("pwmPinLo", 1'b0, pinOut)
		$display("test_pwm done");
	endtask : test_pwm
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// Main sequence
	initial
	begin
		{errors, n_compared, cyc, sys_rst, sclIn, sleepExit} = {96'h0, 3'h6};
		{cfgPulse, cfgMeas, thrWord, hystWord, slow, pwmWave} = 66'h0;
		test_high();
		test_serial();
		test_low();
		test_order();
		test_band();
		test_pwm();
		end_of_test();
	end
endmodule : trl_measure_loop_tb
`default_nettype wire
